// File: rtl/gsc_pkg.sv
package gsc_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned PCYC_US = 5_000;
  localparam int unsigned PCYC_CLKS = CLK_HZ / 1_000_000 * PCYC_US;
  localparam int unsigned MAX_SYNC_MS = 300_000;
  localparam int unsigned MAX_PULSE_MS = 3_000;
  localparam int unsigned CLOSE_LEN_MS = 250;
  localparam int unsigned MAX_SYNC_TICKS = MAX_SYNC_MS * 1000 / PCYC_US;
  localparam logic [15:0] MAX_PULSE_TICKS = 16'(MAX_PULSE_MS * 1000 / PCYC_US);
  localparam logic [15:0] CLOSE_TICKS = 16'(CLOSE_LEN_MS * 1000 / PCYC_US);
  localparam int unsigned PLEN_SHIFT = 16;
  localparam int unsigned PRED_SHIFT = 7;
  localparam logic [15:0] ANG_WIN = 16'h03E8;
  localparam int unsigned NUM_EVT = 10;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_VSTART = 8'h04;
  localparam logic [7:0] REG_FSTART = 8'h08;
  localparam logic [7:0] REG_VUPBLK = 8'h0C;
  localparam logic [7:0] REG_VDNBLK = 8'h10;
  localparam logic [7:0] REG_VINT = 8'h14;
  localparam logic [7:0] REG_VK = 8'h18;
  localparam logic [7:0] REG_FINT = 8'h1C;
  localparam logic [7:0] REG_FK = 8'h20;
  localparam logic [7:0] REG_FILT = 8'h24;
  localparam logic [7:0] REG_PREK = 8'h28;
  localparam logic [7:0] REG_EVMASK = 8'h2C;
  localparam logic [7:0] REG_STATUS = 8'h30;
  localparam logic [7:0] REG_EVT = 8'h34;
  localparam logic [7:0] REG_EVT_TS = 8'h38;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_MULTI_BIT = 1;
  localparam int unsigned EVM_OFF_LSB = 16;
  localparam int unsigned ST_LSB = 16;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [15:0] VSTART_RST = 16'h07D0;
  localparam logic [15:0] FSTART_RST = 16'h01F4;
  localparam logic [15:0] VUPBLK_RST = 16'h07D0;
  localparam logic [15:0] VDNBLK_RST = 16'hF830;
  localparam logic [15:0] VINT_RST = 16'h03E8;
  localparam logic [19:0] VK_RST = 20'h186A0;
  localparam logic [15:0] FINT_RST = 16'h0064;
  localparam logic [19:0] FK_RST = 20'h186A0;
  localparam logic [15:0] FILT_RST = 16'h00C8;
  localparam logic [15:0] PREK_RST = 16'h000A;
  localparam logic [9:0] EVM_RST = 10'h3FF;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_RUN = 6'b000010,
    ST_CLOSE = 6'b000100,
    ST_BLOCKED = 6'b001000,
    ST_FAIL = 6'b010000,
    ST_DONE = 6'b100000
  } gsc_st_t;
  typedef struct packed {
    logic signed [15:0] vdiff;
    logic signed [15:0] fdiff;
    logic signed [15:0] vctrl;
    logic signed [15:0] angle;
  } gsc_meas_t;
  typedef struct packed {
    logic vld;
    logic lost;
    logic rise;
    logic [3:0] code;
    logic [31:0] ts;
  } gsc_evt_t;
endpackage

// File: rtl/gsc_top.sv
// How it works
// - no start while voltage difference exceeds start threshold
// - no start while frequency difference exceeds start limit
// - raise pulses suppressed while controlled voltage above upper level
// - lower pulses suppressed while controlled voltage below lower level
// - voltage deviation integrated; pulse when sum reaches threshold
// - voltage pulse length scaled from base constant
// - frequency deviation integrated; pulse when sum reaches threshold
// - frequency pulse length scaled from base constant
// - angle derivative measured over settable filter window
// - pre-closing constant scales predicted angle for close timing
// - blocking input sampled at start of each program cycle
// - pick-up while unblocked gives breaker close pulse
// - pick-up while blocked gives blocked output, nothing else
// - status changes make events, rise/fall chosen per event
// - each stored event carries a time stamp
// - nine status outputs and the request each give on and off events
// - attempt cancelled after maximum synchronizing time
// - adjustment pulses never exceed maximum pulse length
// - breaker close output held for close pulse length
module gsc_adj
  import gsc_pkg::*;
#(
  parameter int W = 24
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic i_run,
  input wire logic signed [15:0] i_dev,
  input wire logic [15:0] i_thr,
  input wire logic [19:0] i_k,
  input wire logic [15:0] i_max,
  input wire logic i_up_ok,
  input wire logic i_dn_ok,
  output logic o_up,
  output logic o_dn
);
  logic signed [W-1:0] sum_ff, nxt_sum, thr_s;
  logic [15:0] len_ff, nxt_len, mag, pcnt_ff;
  logic [35:0] prod;
  logic up_ff, dn_ff, busy, go_up, go_dn;

  assign busy = up_ff | dn_ff;
  assign thr_s = $signed({{(W-16){1'b0}}, i_thr});
  assign nxt_sum = sum_ff + {{(W-16){i_dev[15]}}, i_dev};
  assign mag = i_dev[15] ? 16'(-i_dev) : i_dev;
  assign prod = 36'(i_k) * 36'(mag);
  assign go_up = i_tick && !busy && nxt_sum >= thr_s && i_up_ok;
  assign go_dn = i_tick && !busy && nxt_sum <= -thr_s && i_dn_ok;
  assign o_up = up_ff;
  assign o_dn = dn_ff;

  always_comb begin
    if (prod[35:PLEN_SHIFT] > 20'(i_max)) begin
      nxt_len = i_max;
    end else if (prod[35:PLEN_SHIFT] == 20'h00000) begin
      nxt_len = 16'h0001;
    end else begin
      nxt_len = prod[PLEN_SHIFT+15:PLEN_SHIFT];
    end
  end

  // a suppressed direction saturates at the threshold, so the sum cannot wrap
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sum_ff <= '0;
    end else if (!i_run) begin
      sum_ff <= '0;
    end else if (i_tick) begin
      if (nxt_sum >= thr_s) begin
        sum_ff <= go_up ? '0 : thr_s;
      end else if (nxt_sum <= -thr_s) begin
        sum_ff <= go_dn ? '0 : -thr_s;
      end else begin
        sum_ff <= nxt_sum;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      up_ff <= 1'b0;
      dn_ff <= 1'b0;
      len_ff <= 16'h0000;
    end else if (!i_run) begin
      up_ff <= 1'b0;
      dn_ff <= 1'b0;
      len_ff <= 16'h0000;
    end else if (go_up || go_dn) begin
      up_ff <= go_up;
      dn_ff <= go_dn;
      len_ff <= nxt_len;
    end else begin
      if (i_tick && len_ff != 16'h0000) begin
        len_ff <= len_ff - 16'h0001;
      end
      if ((i_tick && len_ff == 16'h0001) || !i_up_ok) begin
        up_ff <= 1'b0;
      end
      if ((i_tick && len_ff == 16'h0001) || !i_dn_ok) begin
        dn_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pcnt_ff <= 16'h0000;
    end else if (!busy) begin
      pcnt_ff <= 16'h0000;
    end else if (i_tick) begin
      pcnt_ff <= pcnt_ff + 16'h0001;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  chk_up_block: assert property (up_ff && !i_up_ok && !go_up |=> !up_ff)
    else $error("raise pulse kept above block level");
  chk_dn_block: assert property (dn_ff && !i_dn_ok && !go_dn |=> !dn_ff)
    else $error("lower pulse kept below block level");
  chk_int_clear: assert property ($rose(busy) && i_run |-> sum_ff == '0)
    else $error("integrator not cleared after pulse");
  chk_pulse_max: assert property (pcnt_ff <= i_max)
    else $error("adjustment pulse too long");
endmodule

module gsc_top
  import gsc_pkg::*;
#(
  parameter int unsigned PCYC_CYCLES = PCYC_CLKS,
  parameter int unsigned SYNC_MAX = MAX_SYNC_TICKS
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  input wire gsc_meas_t I_MEAS,
  input wire logic I_REQ,
  input wire logic I_BLOCK,
  input wire logic I_CB_CLOSED,
  output logic O_BLOCKED,
  output logic O_RUNNING,
  output logic O_V_RAISE,
  output logic O_V_LOWER,
  output logic O_F_RAISE,
  output logic O_F_LOWER,
  output logic O_BREAKER_CLOSE_OUTPUT,
  output logic O_LONG_SYNC,
  output logic O_REINIT
);
  localparam int CW = $clog2(PCYC_CYCLES);
  logic [CW-1:0] div_ff;
  logic tick, tick_d_ff, blk_ff, req_ff, cb_ff, reinit_ff, run, vok, fok, aok, pickup;
  logic ack_ff, acc, wr, evt_clr;
  logic [31:0] rdat_ff, rdat, ts_ff;
  logic [1:0] ctrl_ff;
  logic [15:0] vstart_ff, fstart_ff, vup_ff, vdn_ff, vint_ff, fint_ff, filt_ff, prek_ff;
  logic [19:0] vk_ff, fk_ff;
  logic [9:0] evon_ff, evoff_ff, sig, prev_ff, want;
  logic [15:0] close_cnt_ff, wcnt_ff;
  logic [31:0] sync_cnt_ff;
  logic signed [16:0] rate_ff, ang0_ff;
  logic signed [33:0] prod_a;
  logic signed [17:0] pred, win;
  logic rate_vld_ff, vr, vl, fr, fl;
  logic [3:0] pick;
  gsc_st_t st_ff;
  gsc_evt_t evt_ff;

  function automatic logic [15:0] absu(input logic [15:0] x);
    absu = x[15] ? 16'(-x) : x;
  endfunction

  function automatic logic [31:0] bl(input logic [31:0] o, input logic [31:0] d,
                                     input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      bl[8*i+:8] = s[i] ? d[8*i+:8] : o[8*i+:8];
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // program cycle divider; blocking, request and breaker state sampled at its start
  assign tick = (div_ff == CW'(PCYC_CYCLES - 1));

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      div_ff <= '0;
      tick_d_ff <= 1'b0;
      ts_ff <= 32'h0000_0000;
    end else begin
      div_ff <= tick ? '0 : div_ff + CW'(1);
      tick_d_ff <= tick;
      ts_ff <= tick ? ts_ff + 32'h0000_0001 : ts_ff;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      blk_ff <= 1'b0;
      req_ff <= 1'b0;
      cb_ff <= 1'b0;
    end else if (tick) begin
      blk_ff <= I_BLOCK;
      req_ff <= I_REQ;
      cb_ff <= I_CB_CLOSED;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // start window and close prediction
  assign vok = absu(I_MEAS.vdiff) <= vstart_ff;
  assign fok = absu(I_MEAS.fdiff) <= fstart_ff;
  assign prod_a = rate_ff * $signed({1'b0, prek_ff});
  assign pred = 18'(I_MEAS.angle) + 18'(prod_a >>> PRED_SHIFT);
  assign win = $signed({2'b00, ANG_WIN});
  assign aok = (pred <= win) && (pred >= -win);
  assign pickup = rate_vld_ff && aok && vok && fok;
  assign run = (st_ff == ST_RUN);

  // a long filter delays the first valid rate, and so the first close chance
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      wcnt_ff <= 16'h0000;
      rate_ff <= '0;
      ang0_ff <= '0;
      rate_vld_ff <= 1'b0;
    end else if (!run) begin
      wcnt_ff <= 16'h0000;
      rate_vld_ff <= 1'b0;
      ang0_ff <= 17'(I_MEAS.angle);
    end else if (tick_d_ff) begin
      if (wcnt_ff + 16'h0001 >= filt_ff) begin
        rate_ff <= 17'(I_MEAS.angle) - ang0_ff;
        ang0_ff <= 17'(I_MEAS.angle);
        rate_vld_ff <= 1'b1;
        wcnt_ff <= 16'h0000;
      end else begin
        wcnt_ff <= wcnt_ff + 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequence control
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_ff <= ST_IDLE;
    end else if (tick_d_ff) begin
      case (st_ff)
        ST_IDLE: begin
          if (ctrl_ff[CTRL_EN_BIT] && req_ff && vok && fok) begin
            st_ff <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!req_ff || !ctrl_ff[CTRL_EN_BIT]) begin
            st_ff <= ST_IDLE;
          end else if (sync_cnt_ff >= SYNC_MAX) begin
            st_ff <= ST_FAIL;
          end else if (pickup) begin
            st_ff <= blk_ff ? ST_BLOCKED : ST_CLOSE;
          end
        end
        ST_CLOSE: begin
          if (close_cnt_ff == CLOSE_TICKS - 16'h0001) begin
            if (!cb_ff && ctrl_ff[CTRL_MULTI_BIT] && sync_cnt_ff < SYNC_MAX) begin
              st_ff <= ST_RUN;
            end else begin
              st_ff <= ST_DONE;
            end
          end
        end
        ST_BLOCKED, ST_FAIL, ST_DONE: begin
          if (!req_ff) begin
            st_ff <= ST_IDLE;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      reinit_ff <= 1'b0;
    end else if (tick_d_ff) begin
      reinit_ff <= (st_ff == ST_CLOSE) && (close_cnt_ff == CLOSE_TICKS - 16'h0001)
                   && !cb_ff && ctrl_ff[CTRL_MULTI_BIT] && (sync_cnt_ff < SYNC_MAX);
    end
  end

  // retries share one time budget: the sync timer is not restarted on re-init
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sync_cnt_ff <= 32'h0000_0000;
      close_cnt_ff <= 16'h0000;
    end else begin
      if (!(O_RUNNING)) begin
        sync_cnt_ff <= 32'h0000_0000;
      end else if (tick_d_ff && sync_cnt_ff < SYNC_MAX) begin
        sync_cnt_ff <= sync_cnt_ff + 32'h0000_0001;
      end
      if (st_ff != ST_CLOSE) begin
        close_cnt_ff <= 16'h0000;
      end else if (tick_d_ff) begin
        close_cnt_ff <= close_cnt_ff + 16'h0001;
      end
    end
  end

  gsc_adj u_vadj (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RST_N),
    .i_tick(tick),
    .i_run(run),
    .i_dev(I_MEAS.vdiff),
    .i_thr(vint_ff),
    .i_k(vk_ff),
    .i_max(MAX_PULSE_TICKS),
    .i_up_ok($signed(I_MEAS.vctrl) <= $signed(vup_ff)),
    .i_dn_ok($signed(I_MEAS.vctrl) >= $signed(vdn_ff)),
    .o_up(vr),
    .o_dn(vl)
  );

  gsc_adj u_fadj (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RST_N),
    .i_tick(tick),
    .i_run(run),
    .i_dev(I_MEAS.fdiff),
    .i_thr(fint_ff),
    .i_k(fk_ff),
    .i_max(MAX_PULSE_TICKS),
    .i_up_ok(1'b1),
    .i_dn_ok(1'b1),
    .o_up(fr),
    .o_dn(fl)
  );

  assign O_BLOCKED = (st_ff == ST_BLOCKED);
  assign O_RUNNING = (st_ff == ST_RUN) || (st_ff == ST_CLOSE);
  assign O_BREAKER_CLOSE_OUTPUT = (st_ff == ST_CLOSE);
  assign O_LONG_SYNC = (st_ff == ST_FAIL);
  assign O_REINIT = reinit_ff;
  assign O_V_RAISE = vr;
  assign O_V_LOWER = vl;
  assign O_F_RAISE = fr;
  assign O_F_LOWER = fl;

  //////////////////////////////////////////////////////////////////////////////
  // event capture; one record, lowest code wins when several change together
  assign sig = {req_ff, reinit_ff, O_LONG_SYNC, O_BREAKER_CLOSE_OUTPUT, fl, fr, vl, vr,
                O_RUNNING, O_BLOCKED};
  assign want = (sig ^ prev_ff) & ((sig & evon_ff) | (~sig & evoff_ff));

  always_comb begin
    pick = 4'h0;
    for (int i = NUM_EVT - 1; i >= 0; i--) begin
      if (want[i]) begin
        pick = 4'(i);
      end
    end
  end

  // a new event beats a read-clear in the same cycle
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      prev_ff <= 10'h000;
      evt_ff <= '0;
    end else begin
      prev_ff <= sig;
      if (want != 10'h000) begin
        evt_ff.vld <= 1'b1;
        evt_ff.lost <= (evt_ff.lost && !evt_clr) || (evt_ff.vld && !evt_clr)
                       || ((want & (want - 10'h001)) != 10'h000);
        evt_ff.rise <= sig[pick];
        evt_ff.code <= pick;
        evt_ff.ts <= ts_ff;
      end else if (evt_clr) begin
        evt_ff.vld <= 1'b0;
        evt_ff.lost <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after the strobe, write lands on the ack edge
  assign acc = I_WB_CYC && I_WB_STB;
  assign wr = acc && ack_ff && I_WB_WE;
  assign evt_clr = acc && ack_ff && !I_WB_WE && (I_WB_ADR == REG_EVT);
  assign O_WB_ACK = ack_ff;
  assign O_WB_DAT = rdat_ff;

  always_comb begin
    case (I_WB_ADR)
      REG_CTRL: rdat = {30'h0000_0000, ctrl_ff};
      REG_VSTART: rdat = {16'h0000, vstart_ff};
      REG_FSTART: rdat = {16'h0000, fstart_ff};
      REG_VUPBLK: rdat = {16'h0000, vup_ff};
      REG_VDNBLK: rdat = {16'h0000, vdn_ff};
      REG_VINT: rdat = {16'h0000, vint_ff};
      REG_VK: rdat = {12'h000, vk_ff};
      REG_FINT: rdat = {16'h0000, fint_ff};
      REG_FK: rdat = {12'h000, fk_ff};
      REG_FILT: rdat = {16'h0000, filt_ff};
      REG_PREK: rdat = {16'h0000, prek_ff};
      REG_EVMASK: rdat = {6'h00, evoff_ff, 6'h00, evon_ff};
      REG_STATUS: rdat = {10'h000, st_ff, 6'h00, sig};
      REG_EVT: rdat = {evt_ff.vld, evt_ff.lost, evt_ff.rise, 25'h000_0000, evt_ff.code};
      REG_EVT_TS: rdat = evt_ff.ts;
      default: rdat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= acc && !ack_ff;
      if (acc && !ack_ff) begin
        rdat_ff <= rdat;
      end
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl_ff <= CTRL_RST;
      vstart_ff <= VSTART_RST;
      fstart_ff <= FSTART_RST;
      vup_ff <= VUPBLK_RST;
      vdn_ff <= VDNBLK_RST;
      vint_ff <= VINT_RST;
      vk_ff <= VK_RST;
      fint_ff <= FINT_RST;
      fk_ff <= FK_RST;
      filt_ff <= FILT_RST;
      prek_ff <= PREK_RST;
      evon_ff <= EVM_RST;
      evoff_ff <= EVM_RST;
    end else if (wr) begin
      case (I_WB_ADR)
        REG_CTRL: ctrl_ff <= 2'(bl(32'(ctrl_ff), I_WB_DAT, I_WB_SEL));
        REG_VSTART: vstart_ff <= 16'(bl(32'(vstart_ff), I_WB_DAT, I_WB_SEL));
        REG_FSTART: fstart_ff <= 16'(bl(32'(fstart_ff), I_WB_DAT, I_WB_SEL));
        REG_VUPBLK: vup_ff <= 16'(bl(32'(vup_ff), I_WB_DAT, I_WB_SEL));
        REG_VDNBLK: vdn_ff <= 16'(bl(32'(vdn_ff), I_WB_DAT, I_WB_SEL));
        REG_VINT: vint_ff <= 16'(bl(32'(vint_ff), I_WB_DAT, I_WB_SEL));
        REG_VK: vk_ff <= 20'(bl(32'(vk_ff), I_WB_DAT, I_WB_SEL));
        REG_FINT: fint_ff <= 16'(bl(32'(fint_ff), I_WB_DAT, I_WB_SEL));
        REG_FK: fk_ff <= 20'(bl(32'(fk_ff), I_WB_DAT, I_WB_SEL));
        REG_FILT: filt_ff <= 16'(bl(32'(filt_ff), I_WB_DAT, I_WB_SEL));
        REG_PREK: prek_ff <= 16'(bl(32'(prek_ff), I_WB_DAT, I_WB_SEL));
        REG_EVMASK: begin
          evon_ff <= 10'(bl({22'h00_0000, evon_ff}, I_WB_DAT, I_WB_SEL));
          evoff_ff <= 10'(bl(I_WB_DAT, I_WB_DAT, I_WB_SEL) >> EVM_OFF_LSB) & evoff_ff
                      | 10'(bl(32'h0000_0000, I_WB_DAT, I_WB_SEL) >> EVM_OFF_LSB)
                      | (I_WB_SEL[2] ? 10'h000 : evoff_ff & 10'h0FF)
                      | (I_WB_SEL[3] ? 10'h000 : evoff_ff & 10'h300);
        end
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence s_pick_free;
    run && tick_d_ff && ctrl_ff[CTRL_EN_BIT] && req_ff && sync_cnt_ff < SYNC_MAX && pickup
    && !blk_ff;
  endsequence
  sequence s_closing;
    O_BREAKER_CLOSE_OUTPUT && O_RUNNING;
  endsequence
  chk_start_vlim: assert property ($rose(run) && $past(st_ff == ST_IDLE)
    |-> $past(vok))
    else $error("start with voltage difference too large");
  chk_start_flim: assert property ($rose(run) && $past(st_ff == ST_IDLE)
    |-> $past(fok))
    else $error("start with frequency difference too large");
  chk_close_pick: assert property (s_pick_free |=> s_closing)
    else $error("unblocked pick-up gave no close pulse");
  chk_block_pick: assert property (s_pick_free or (run && tick_d_ff && req_ff && pickup
    && ctrl_ff[CTRL_EN_BIT] && sync_cnt_ff < SYNC_MAX) |=> O_BLOCKED == $past(blk_ff)
    && O_BREAKER_CLOSE_OUTPUT != $past(blk_ff))
    else $error("blocked pick-up handled wrong");
  chk_close_len: assert property ($fell(O_BREAKER_CLOSE_OUTPUT)
    |-> $past(close_cnt_ff) == CLOSE_TICKS - 16'h0001)
    else $error("close pulse length wrong");
  chk_sync_max: assert property (sync_cnt_ff <= SYNC_MAX)
    else $error("sync timer overran maximum");
  chk_evt_store: assert property (want != 10'h000 |=> evt_ff.vld
    && evt_ff.code == $past(pick) && evt_ff.ts == $past(ts_ff))
    else $error("event not stored with time stamp");
  chk_blk_sample: assert property (tick |=> blk_ff == $past(I_BLOCK))
    else $error("block input not sampled at cycle start");
endmodule

// File: sim/gsc_plant.sv
module gsc_plant (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_close,
  input wire logic i_open,
  output logic o_closed
);
  timeunit 1ns;
  timeprecision 1ns;
  // breaker latches closed on a close command; only the bench opens it again
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_closed <= 1'b0;
    end else if (i_open) begin
      o_closed <= 1'b0;
    end else if (i_close) begin
      o_closed <= 1'b1;
    end
  end
endmodule

// File: sim/gsc_top_tb.sv
module gsc_top_tb import gsc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned PC = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, req = 1'b0, blk = 1'b0, opn = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, blkd, run, vr, vl, fr, fl, cls, lng, rei, cb;
  gsc_meas_t meas = '0;
  int num_errors = 0;
  int n_compared = 0;
  wire logic [8:0] watch = {rei, lng, fl, fr, vl, run, blkd, cls, vr};
  // timer long enough that a full close pulse plus a retry fits inside it
  gsc_top #(.PCYC_CYCLES(PC), .SYNC_MAX(80)) i_dut (.I_REF_CLK(clk), .I_RST_N(rst_n),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF),
    .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_MEAS(meas), .I_REQ(req),
    .I_BLOCK(blk), .I_CB_CLOSED(cb), .O_BLOCKED(blkd), .O_RUNNING(run), .O_V_RAISE(vr),
    .O_V_LOWER(vl), .O_F_RAISE(fr), .O_F_LOWER(fl), .O_BREAKER_CLOSE_OUTPUT(cls),
    .O_LONG_SYNC(lng), .O_REINIT(rei));
  gsc_plant i_plant (.i_clk(clk), .i_rst_n(rst_n), .i_close(cls), .i_open(opn),
    .o_closed(cb));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle; no ack count is assumed, only the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n * PC) @(posedge clk);
  endtask
  task automatic wait_hi(input int i);
    int n;
    n = 0;
    while (watch[i] !== 1'b1 && n < 100 * PC) begin
      @(posedge clk);
      n++;
    end
    chk(32'(watch[i]), 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] a[8] = '{REG_VSTART, REG_FSTART, REG_VINT, REG_VK, REG_FK, REG_FILT,
      REG_PREK, 8'h3C};
    logic [31:0] e[8] = '{32'h7D0, 32'h1F4, 32'h3E8, 32'h186A0, 32'h186A0, 32'hC8,
      32'hA, 32'h0};
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, a[i], 32'h0);
      chk(q, e[i]);
    end
  endtask
  // a far-off angle keeps pick-up away until the adjustment checks are done
  task automatic t_adj();
    int n;
    wb(1'b1, REG_CTRL, 32'h1);
    wb(1'b1, REG_FILT, 32'h2);
    wb(1'b1, REG_VK, 32'h1);
    @(posedge clk);
    meas.vdiff <= 16'sd2001;
    meas.angle <= 16'h1388;
    req <= 1'b1;
    ticks(6);
    chk(32'(run), 32'h0);
    meas.vdiff <= 16'sd500;
    meas.fdiff <= 16'sd501;
    ticks(6);
    chk(32'(run), 32'h0);
    meas.fdiff <= 16'sd100;
    meas.vctrl <= 16'sd2001;
    wait_hi(3);
    wait_hi(5);
    ticks(6);
    chk(32'(vr), 32'h0);
    meas.vctrl <= 16'sd0;
    wait_hi(0);
    meas.vdiff <= 16'sd0;
    meas.angle <= 16'h0000;
    wait_hi(1);
    n = 0;
    while (cls === 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n), 32'(50 * PC));
    ticks(2);
    chk(32'(run), 32'h0);
    wb(1'b0, REG_EVT, 32'h0);
    chk(q, 32'hC000_0001);
    wb(1'b0, REG_EVT, 32'h0);
    chk(q, 32'h0000_0001);
    wb(1'b0, REG_EVT_TS, 32'h0);
    chk(32'(q != 32'h0), 32'h1);
    req <= 1'b0;
    opn <= 1'b1;
    ticks(3);
    opn <= 1'b0;
  endtask
  task automatic t_block();
    @(posedge clk);
    blk <= 1'b1;
    ticks(2);
    req <= 1'b1;
    wait_hi(2);
    ticks(60);
    chk(32'({cls, run}), 32'h0);
    req <= 1'b0;
    blk <= 1'b0;
    ticks(2);
  endtask
  // lower side: voltage lower held off below the block level, then the timer runs out
  task automatic t_long();
    @(posedge clk);
    meas.vdiff <= 16'hFE0C;
    meas.fdiff <= 16'hFF9C;
    meas.vctrl <= 16'hF82F;
    meas.angle <= 16'h1388;
    req <= 1'b1;
    wait_hi(3);
    wait_hi(6);
    ticks(6);
    chk(32'(vl), 32'h0);
    meas.vctrl <= 16'h0000;
    wait_hi(4);
    wait_hi(7);
    ticks(1);
    chk(32'(run | fl), 32'h0);
    req <= 1'b0;
    meas <= '0;
    ticks(2);
  endtask
  // breaker held open, so a multi-try attempt re-initialises after the close pulse
  task automatic t_reinit();
    wb(1'b1, REG_CTRL, 32'h3);
    @(posedge clk);
    opn <= 1'b1;
    req <= 1'b1;
    wait_hi(8);
    chk(32'({run, cls}), 32'h2);
    req <= 1'b0;
    opn <= 1'b0;
    ticks(2);
  endtask
  task automatic complete_run();
    if (num_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_adj();
    t_block();
    t_long();
    t_reinit();
    complete_run();
  end
  // whole run needs a few thousand clocks; this bound leaves ample margin
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule
